/* File: design/rlss_pkg.sv */
// package of the radio link settings store: framing codes, setting indices,
// reset values, mode codes and the settings carrier.
// assumes a byte-wide command stream on the same clock as the store.
// Function
// - radio traffic lengths are limited by applied maximum frame length, default 250.
// - frames longer than the maximum are dropped with no host notice.
// - written settings are stored only; applied at restart command or pin reset.
// - successful write answers FF, 89, 01, status 00, checksum.
// - decryption runs only when index 0x0B set and sender key registered.
// - radio receiver is inactive while a frame is being decrypted.
// - power index 1 to 6 maps to -5,0,+5,+7,+10,+11 dBm.
// - strength enable at 0x45 appends strength byte as last payload byte.
// - with strength on, serial length plus one, radio limit max minus one.
// - link mode at 0x46 accepts listed codes; 02, 05, 0C transmit only.
// - code 09 is receive-only gateway; transmitting needs 08 or 0E.
// - C and N modes receive A and B, transmit last format, start A; a C frame taken in the restart cycle sets the format instead.
// - S, F and T modes use frame format A only.
package rlss_pkg;

    // ************************************************************
    // framing
    // ************************************************************
    localparam logic [7:0] FRAME_START = 8'hFF;
    localparam logic [7:0] CMD_SET_WRITE = 8'h09;
    localparam logic [7:0] CMD_SET_ANSWER = 8'h89;
    localparam logic [7:0] SET_LEN = 8'h03;
    localparam logic [7:0] PARAM_LEN = 8'h01;
    localparam logic [7:0] ANSWER_LEN = 8'h01;
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_FAIL = 8'h01;

    // ************************************************************
    // setting indices and reset values
    // ************************************************************
    localparam logic [7:0] IDX_MAX_FRAME_LENGTH = 8'h0A;
    localparam logic [7:0] IDX_DECRYPT_ENABLE = 8'h0B;
    localparam logic [7:0] IDX_TX_POWER_INDEX = 8'h3D;
    localparam logic [7:0] IDX_STRENGTH_APPEND_ENABLE = 8'h45;
    localparam logic [7:0] IDX_DEFAULT_LINK_MODE = 8'h46;
    localparam logic [7:0] RST_MAX_FRAME_LENGTH = 8'hFA;
    localparam logic [7:0] RST_DECRYPT_ENABLE = 8'h00;
    localparam logic [7:0] RST_TX_POWER_INDEX = 8'h06;
    localparam logic [7:0] RST_STRENGTH_APPEND_ENABLE = 8'h00;
    localparam logic [7:0] RST_DEFAULT_LINK_MODE = 8'h03;

    // ************************************************************
    // link mode codes
    // ************************************************************
    localparam logic [7:0] MODE_S_METER_TX = 8'h02;
    localparam logic [7:0] MODE_S2 = 8'h03;
    localparam logic [7:0] MODE_T_METER_TX = 8'h05;
    localparam logic [7:0] MODE_T2_METER = 8'h07;
    localparam logic [7:0] MODE_T_GATEWAY = 8'h08;
    localparam logic [7:0] MODE_DUAL_RECEIVE_GATEWAY = 8'h09;
    localparam logic [7:0] MODE_C_METER_TX = 8'h0C;
    localparam logic [7:0] MODE_C2_METER = 8'h0D;
    localparam logic [7:0] MODE_C_GATEWAY = 8'h0E;

    typedef struct packed {
        logic [7:0] max_frame_length;
        logic [7:0] decrypt_enable;
        logic [7:0] tx_power_index;
        logic [7:0] strength_append_enable;
        logic [7:0] default_link_mode;
    } rlss_settings_type;

    localparam rlss_settings_type RST_SETTINGS = '{
        RST_MAX_FRAME_LENGTH, RST_DECRYPT_ENABLE, RST_TX_POWER_INDEX,
        RST_STRENGTH_APPEND_ENABLE, RST_DEFAULT_LINK_MODE};

    function automatic logic mode_listed(input logic [7:0] code);
        case (code)
            MODE_S_METER_TX, MODE_S2, MODE_T_METER_TX, MODE_T2_METER, MODE_T_GATEWAY,
            MODE_DUAL_RECEIVE_GATEWAY, MODE_C_METER_TX, MODE_C2_METER,
            MODE_C_GATEWAY: mode_listed = 1'b1;
            default: mode_listed = 1'b0;
        endcase
    endfunction

    function automatic logic signed [7:0] power_dbm(input logic [7:0] idx);
        case (idx)
            8'h01: power_dbm = -8'sd5;
            8'h02: power_dbm = 8'sd0;
            8'h03: power_dbm = 8'sd5;
            8'h04: power_dbm = 8'sd7;
            8'h05: power_dbm = 8'sd10;
            8'h06: power_dbm = 8'sd11;
            default: power_dbm = 8'sd0;
        endcase
    endfunction

endpackage

/* File: design/rlss_answer_tx.sv */
// answer sender: emits the five-byte write answer with its running checksum.
// assumes a downstream byte sink with valid/ready on the same clock.
`timescale 1ns/1ns
module rlss_answer_tx (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // request
    input wire logic start_i,
    input wire logic [7:0] status_i,
    output logic busy_o,
    // byte stream out
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i
);
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic [7:0] status_ff;
    logic [7:0] csum_ff;
    logic [7:0] nxt_byte;
    wire logic step = tx_valid_o && tx_ready_i;

    // ************************************************************
    // byte selection
    // ************************************************************
    always_comb begin
        case (cnt_ff)
            3'd1: nxt_byte = rlss_pkg::FRAME_START;
            3'd2: nxt_byte = rlss_pkg::CMD_SET_ANSWER;
            3'd3: nxt_byte = rlss_pkg::ANSWER_LEN;
            3'd4: nxt_byte = status_ff;
            3'd5: nxt_byte = csum_ff;
            default: nxt_byte = 8'h00;
        endcase
    end

    assign nxt_cnt = (cnt_ff == 3'd5) ? 3'd0 : cnt_ff + 3'd1;
    assign busy_o = (cnt_ff != 3'd0);
    assign tx_valid_o = busy_o;
    assign tx_data_o = nxt_byte;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 3'd0;
            status_ff <= 8'h00;
            csum_ff <= 8'h00;
        end else if (start_i && !busy_o) begin
            cnt_ff <= 3'd1;
            status_ff <= status_i;
            csum_ff <= 8'h00;
        end else if (step) begin
            cnt_ff <= nxt_cnt;
            csum_ff <= csum_ff ^ nxt_byte;
        end
    end
endmodule

/* File: design/rlss_top.sv */
// radio link settings store: parses setting writes, keeps stored and applied
// settings, and derives the radio-side controls from the applied set.
// assumes the host byte stream and radio status signals share clk_i.
`timescale 1ns/1ns
module rlss_top #(
    parameter int BYTE_W = 8
) (
    // clock and reset (pin reset applies stored settings)
    input wire logic clk_i,
    input wire logic rst_n_i,
    // host command stream in
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    // answer stream out
    output logic [7:0] ans_data_o,
    output logic ans_valid_o,
    input wire logic ans_ready_i,
    // restart command
    input wire logic restart_i,
    // radio receive side
    input wire logic rx_frame_valid_i,
    input wire logic [7:0] rx_frame_len_i,
    input wire logic rx_frame_format_b_i,
    output logic rx_accept_o,
    output logic rx_drop_o,
    output logic [7:0] serial_len_o,
    // decryption
    input wire logic key_registered_i,
    input wire logic decrypt_busy_i,
    output logic decrypt_run_o,
    output logic rx_enable_o,
    // radio transmit side
    input wire logic [7:0] tx_req_len_i,
    output logic tx_len_ok_o,
    output logic signed [7:0] tx_power_dbm_o,
    output logic append_strength_o,
    output logic tx_allowed_o,
    output logic rx_allowed_o,
    output logic tx_format_b_o,
    // settings view
    output rlss_pkg::rlss_settings_type stored_o,
    output rlss_pkg::rlss_settings_type applied_o
);
    generate
        if (BYTE_W != 8) begin : g_bad_width
            $error("rlss_top supports only 8-bit bytes");
        end
    endgenerate

    typedef enum logic [2:0] {
        RLSS_IDLE, RLSS_CMD, RLSS_LEN, RLSS_IDX, RLSS_PLEN, RLSS_VAL, RLSS_CSUM
    } rlss_state_type;

    rlss_state_type state_ff;
    rlss_state_type nxt_state;
    logic [7:0] csum_ff;
    logic [7:0] idx_ff;
    logic [7:0] val_ff;
    logic hdr_ok_ff;
    logic nxt_hdr_ok;
    logic fmt_b_ff;
    // power-up contents of the non-volatile copy; pin reset leaves it alone
    rlss_pkg::rlss_settings_type stored_ff = rlss_pkg::RST_SETTINGS;
    logic load_ff;
    rlss_pkg::rlss_settings_type applied_ff;
    rlss_pkg::rlss_settings_type nxt_stored;
    logic ans_busy;
    logic ans_start;
    logic [7:0] ans_status;

    // ************************************************************
    // command parser
    // ************************************************************
    wire logic take = cmd_valid_i && cmd_ready_o;
    wire logic csum_good = (cmd_data_i == csum_ff);
    wire logic idx_known = (idx_ff == rlss_pkg::IDX_MAX_FRAME_LENGTH)
        || (idx_ff == rlss_pkg::IDX_DECRYPT_ENABLE)
        || (idx_ff == rlss_pkg::IDX_TX_POWER_INDEX)
        || (idx_ff == rlss_pkg::IDX_STRENGTH_APPEND_ENABLE)
        || (idx_ff == rlss_pkg::IDX_DEFAULT_LINK_MODE);
    wire logic mode_bad = (idx_ff == rlss_pkg::IDX_DEFAULT_LINK_MODE)
        && !rlss_pkg::mode_listed(val_ff);
    wire logic write_ok = hdr_ok_ff && idx_known && !mode_bad;
    wire logic frame_end = take && (state_ff == RLSS_CSUM) && csum_good;

    assign cmd_ready_o = !((state_ff == RLSS_CSUM) && ans_busy);
    assign ans_start = frame_end;
    assign ans_status = write_ok ? rlss_pkg::STATUS_OK : rlss_pkg::STATUS_FAIL;

    always_comb begin
        nxt_state = state_ff;
        nxt_hdr_ok = hdr_ok_ff;
        case (state_ff)
            RLSS_IDLE: begin
                nxt_hdr_ok = 1'b1;
                if (cmd_data_i == rlss_pkg::FRAME_START) begin
                    nxt_state = RLSS_CMD;
                end
            end
            RLSS_CMD: begin
                nxt_state = (cmd_data_i == rlss_pkg::CMD_SET_WRITE) ? RLSS_LEN : RLSS_IDLE;
            end
            RLSS_LEN: begin
                nxt_state = (cmd_data_i == rlss_pkg::SET_LEN) ? RLSS_IDX : RLSS_IDLE;
            end
            RLSS_IDX: nxt_state = RLSS_PLEN;
            RLSS_PLEN: begin
                nxt_state = RLSS_VAL;
                nxt_hdr_ok = (cmd_data_i == rlss_pkg::PARAM_LEN);
            end
            RLSS_VAL: nxt_state = RLSS_CSUM;
            RLSS_CSUM: nxt_state = RLSS_IDLE;
            default: nxt_state = RLSS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= RLSS_IDLE;
            hdr_ok_ff <= 1'b0;
            csum_ff <= 8'h00;
            idx_ff <= 8'h00;
            val_ff <= 8'h00;
        end else if (take) begin
            state_ff <= nxt_state;
            hdr_ok_ff <= nxt_hdr_ok;
            csum_ff <= (state_ff == RLSS_IDLE) ? cmd_data_i : csum_ff ^ cmd_data_i;
            if (state_ff == RLSS_IDX) begin
                idx_ff <= cmd_data_i;
            end
            if (state_ff == RLSS_VAL) begin
                val_ff <= cmd_data_i;
            end
        end
    end

    // ************************************************************
    // stored and applied settings
    // ************************************************************
    always_comb begin
        nxt_stored = stored_ff;
        case (idx_ff)
            rlss_pkg::IDX_MAX_FRAME_LENGTH: nxt_stored.max_frame_length = val_ff;
            rlss_pkg::IDX_DECRYPT_ENABLE: nxt_stored.decrypt_enable = val_ff;
            rlss_pkg::IDX_TX_POWER_INDEX: nxt_stored.tx_power_index = val_ff;
            rlss_pkg::IDX_STRENGTH_APPEND_ENABLE: nxt_stored.strength_append_enable = val_ff;
            rlss_pkg::IDX_DEFAULT_LINK_MODE: nxt_stored.default_link_mode = val_ff;
            default: nxt_stored = stored_ff;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (frame_end && write_ok) begin
            stored_ff <= nxt_stored;
        end
    end

    // pin reset starts from defaults and reloads the stored set on the first edge after it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            applied_ff <= rlss_pkg::RST_SETTINGS;
            load_ff <= 1'b1;
        end else begin
            load_ff <= 1'b0;
            if (restart_i || load_ff) begin
                applied_ff <= stored_ff;
            end
        end
    end

    assign stored_o = stored_ff;
    assign applied_o = applied_ff;

    // ************************************************************
    // radio side controls from the applied set
    // ************************************************************
    wire logic strength_on = (applied_ff.strength_append_enable == 8'h01);
    wire logic [7:0] radio_limit = applied_ff.max_frame_length - {7'd0, strength_on};
    wire logic [7:0] mode = applied_ff.default_link_mode;
    wire logic tx_only = (mode == rlss_pkg::MODE_S_METER_TX)
        || (mode == rlss_pkg::MODE_T_METER_TX)
        || (mode == rlss_pkg::MODE_C_METER_TX);
    wire logic c_family = (mode == rlss_pkg::MODE_C_METER_TX)
        || (mode == rlss_pkg::MODE_C2_METER)
        || (mode == rlss_pkg::MODE_C_GATEWAY)
        || (mode == rlss_pkg::MODE_DUAL_RECEIVE_GATEWAY);
    wire logic len_fits = (rx_frame_len_i <= radio_limit);

    assign append_strength_o = strength_on;
    assign tx_len_ok_o = (tx_req_len_i <= radio_limit);
    assign tx_power_dbm_o = rlss_pkg::power_dbm(applied_ff.tx_power_index);
    assign tx_allowed_o = rlss_pkg::mode_listed(mode)
        && (mode != rlss_pkg::MODE_DUAL_RECEIVE_GATEWAY);
    assign rx_allowed_o = rlss_pkg::mode_listed(mode) && !tx_only;
    assign decrypt_run_o = (applied_ff.decrypt_enable == 8'h01) && key_registered_i;
    assign rx_enable_o = rx_allowed_o && !(decrypt_run_o && decrypt_busy_i);
    assign tx_format_b_o = fmt_b_ff && c_family;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_accept_o <= 1'b0;
            rx_drop_o <= 1'b0;
            serial_len_o <= 8'h00;
            fmt_b_ff <= 1'b0;
        end else begin
            rx_accept_o <= rx_frame_valid_i && rx_allowed_o && len_fits;
            rx_drop_o <= rx_frame_valid_i && rx_allowed_o && !len_fits;
            if (rx_frame_valid_i && len_fits) begin
                serial_len_o <= rx_frame_len_i + {7'd0, strength_on};
            end
            if (rx_frame_valid_i && rx_allowed_o && len_fits && c_family) begin
                fmt_b_ff <= rx_frame_format_b_i;
            end else if (restart_i) begin
                fmt_b_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // answer sender
    // ************************************************************
    rlss_answer_tx u_answer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(ans_start),
        .status_i(ans_status),
        .busy_o(ans_busy),
        .tx_data_o(ans_data_o),
        .tx_valid_o(ans_valid_o),
        .tx_ready_i(ans_ready_i)
    );
endmodule

/* File: verification/rlss_checker.sv */
// checker: port relations of the settings store
// assumes it is bound onto rlss_top
`timescale 1ns/1ns
module rlss_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // answer stream
    input wire logic cmd_ready_o,
    input wire logic [7:0] ans_data_o,
    input wire logic ans_valid_o,
    input wire logic ans_ready_i,
    // radio side
    input wire logic restart_i,
    input wire logic rx_frame_valid_i,
    input wire logic [7:0] rx_frame_len_i,
    input wire logic rx_accept_o,
    input wire logic rx_drop_o,
    input wire logic [7:0] serial_len_o,
    input wire logic key_registered_i,
    input wire logic decrypt_busy_i,
    input wire logic decrypt_run_o,
    input wire logic rx_enable_o,
    input wire logic tx_allowed_o,
    input wire logic rx_allowed_o,
    input wire logic tx_format_b_o,
    // settings
    input wire rlss_pkg::rlss_settings_type stored_o,
    input wire rlss_pkg::rlss_settings_type applied_o
);
    // ************
    // properties
    // ************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire [7:0] md = applied_o.default_link_mode;
    wire str = applied_o.strength_append_enable == 8'h01;
    wire [7:0] lim = applied_o.max_frame_length - {7'h00, str};
    wire [7:0] exp_len = rx_frame_len_i + {7'h00, str};
    wire rx_ok = rx_frame_valid_i && rx_allowed_o;
    wire tx_only = md == 8'h02 || md == 8'h05 || md == 8'h0C;
    wire fmt_a = tx_only && md != 8'h0C || md == 8'h03 || md == 8'h07 || md == 8'h08;
    property p_ans_start; $rose(ans_valid_o) |-> ans_data_o == 8'hFF; endproperty
    a_ans_start: assert property (p_ans_start) else $error("answer start");
    property p_ans_hold; ans_valid_o && !ans_ready_i |=> ans_valid_o && $stable(ans_data_o); endproperty
    a_ans_hold: assert property (p_ans_hold) else $error("answer hold");
    property p_drop; rx_ok && rx_frame_len_i > lim |=> rx_drop_o && !rx_accept_o; endproperty
    a_drop: assert property (p_drop) else $error("long frame kept");
    property p_accept;
        rx_ok && rx_frame_len_i <= lim |=> rx_accept_o && serial_len_o == $past(exp_len);
    endproperty
    a_accept: assert property (p_accept) else $error("frame accept");
    property p_hold; !restart_i && $past(rst_n_i) |=> $stable(applied_o); endproperty
    a_hold: assert property (p_hold) else $error("applied early");
    property p_restart; restart_i |=> applied_o == $past(stored_o); endproperty
    a_restart: assert property (p_restart) else $error("restart apply");
    property p_decrypt;
        decrypt_run_o == (applied_o.decrypt_enable == 8'h01 && key_registered_i);
    endproperty
    a_decrypt: assert property (p_decrypt) else $error("decrypt run");
    property p_rx_off; decrypt_run_o && decrypt_busy_i |-> !rx_enable_o; endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx during decrypt");
    property p_rx_only; md == 8'h09 |-> !tx_allowed_o && rx_allowed_o; endproperty
    a_rx_only: assert property (p_rx_only) else $error("gateway mode");
    property p_tx_only; tx_only |-> tx_allowed_o && !rx_allowed_o; endproperty
    a_tx_only: assert property (p_tx_only) else $error("tx only mode");
    property p_fmt_a; fmt_a |-> !tx_format_b_o; endproperty
    a_fmt_a: assert property (p_fmt_a) else $error("format b used");
    property p_ready; !cmd_ready_o |-> ans_valid_o; endproperty
    a_ready: assert property (p_ready) else $error("command stall");
    c_drop: cover property (rx_drop_o);
    c_cmd_stall: cover property (!cmd_ready_o);
    c_restart: cover property (restart_i);
    c_stall: cover property (ans_valid_o && !ans_ready_i);
endmodule

bind rlss_top rlss_checker rlss_checker_i (.*);

/* File: verification/rlss_host_model.sv */
// host model: frames setting writes and takes answers
// assumes the store's byte handshake on clk_i
`timescale 1ns/1ns
module rlss_host_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench control
    input wire logic slow_i,
    // streams
    input wire logic cmd_ready_i,
    output logic [7:0] data_o = 8'h00,
    output logic valid_o = 1'b0,
    output logic ans_ready_o = 1'b0
);
    logic [7:0] tx_q[$];
    int seed = 32'h5a23a8f1;
    task automatic send(input logic [7:0] idx, val, input logic bad);
        logic [7:0] f [6];
        logic [7:0] cs;
        f = '{8'hFF, 8'h09, 8'h03, idx, 8'h01, val};
        cs = 8'h00;
        foreach (f[k]) begin
            cs = cs ^ f[k];
            tx_q.push_back(f[k]);
        end
        tx_q.push_back(cs ^ {7'h00, bad});
    endtask
    // idle data toggles so a stale byte is never mistaken for a new one
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_q.delete();
            valid_o <= 1'b0;
            ans_ready_o <= 1'b0;
        end else begin
            if (valid_o && cmd_ready_i)
                void'(tx_q.pop_front());
            valid_o <= tx_q.size() != 0;
            data_o <= (tx_q.size() != 0) ? tx_q[0] : ~data_o;
            ans_ready_o <= slow_i ? 1'($random(seed)) : 1'b1;
        end
    end
endmodule

/* File: verification/rlss_top_tb.sv */
// testbench of the settings store: host frames, radio stimulus, answer scoreboard
// assumes package, design, host model and checker are compiled first
`timescale 1ns/1ns
module rlss_top_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic slow = 1'b0;
    logic [7:0] cmd_data_i, ans_data_o, serial_len_o;
    logic cmd_valid_i, cmd_ready_o, ans_valid_o, ans_ready_i;
    logic restart_i = 1'b0;
    logic rx_frame_valid_i = 1'b0;
    logic [7:0] rx_frame_len_i = 8'h00;
    logic rx_frame_format_b_i = 1'b0;
    logic key_registered_i = 1'b0;
    logic decrypt_busy_i = 1'b0;
    logic [7:0] tx_req_len_i = 8'h00;
    logic rx_accept_o, rx_drop_o, rx_enable_o, decrypt_run_o, tx_len_ok_o;
    logic append_strength_o, tx_allowed_o, rx_allowed_o, tx_format_b_o;
    logic signed [7:0] tx_power_dbm_o;
    rlss_pkg::rlss_settings_type stored_o, applied_o, exp_set;
    int err_total = 0;
    int total_checks = 0;
    int seed = 32'h5a23a8f1;
    logic [7:0] exp_q[$];
    logic [7:0] modes [9] = '{8'h02, 8'h03, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0C, 8'h0D, 8'h0E};
    logic signed [7:0] dbm [6] = '{-8'sd5, 8'sd0, 8'sd5, 8'sd7, 8'sd10, 8'sd11};
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    rlss_top rlss_top_i (.*);
    rlss_host_model rlss_host_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .cmd_ready_i(cmd_ready_o), .data_o(cmd_data_i), .valid_o(cmd_valid_i),
        .ans_ready_o(ans_ready_i));
    // ************
    // tasks
    // ************
    task automatic check(input logic [39:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] idx, val, input logic bad, input logic [7:0] st);
        logic [7:0] a [5];
        rlss_host_model_i.send(idx, val, bad);
        a = '{8'hFF, 8'h89, 8'h01, st, 8'hFF ^ 8'h89 ^ 8'h01 ^ st};
        if (!bad)
            foreach (a[k]) exp_q.push_back(a[k]);
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (n < 500 && (exp_q.size() != 0 || rlss_host_model_i.tx_q.size() != 0)) begin
            @(posedge clk_i);
            n++;
        end
        check(n < 500, 1'b1);
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic rx(input logic [7:0] len, input logic fb, acc);
        @(posedge clk_i);
        rx_frame_len_i <= len;
        rx_frame_format_b_i <= fb;
        rx_frame_valid_i <= 1'b1;
        @(posedge clk_i);
        rx_frame_valid_i <= 1'b0;
        #1;
        check(rx_accept_o, acc);
        check(rx_drop_o, !acc);
    endtask
    task automatic restart();
        @(posedge clk_i);
        restart_i <= 1'b1;
        @(posedge clk_i);
        restart_i <= 1'b0;
        #1;
    endtask
    // answer scoreboard
    always @(posedge clk_i) begin
        if (rst_n_i && ans_valid_o === 1'b1 && ans_ready_i === 1'b1) begin
            check(exp_q.size() != 0, 1'b1);
            if (exp_q.size() != 0)
                check(ans_data_o, exp_q.pop_front());
        end
    end
    // watchdog: the run needs a few thousand cycles at most
    initial begin
        #300000;
        err_total++;
        summarize();
    end
    // ************
    // scenarios
    // ************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        check(stored_o, rlss_pkg::RST_SETTINGS);
        check(applied_o.max_frame_length, 8'hFA);
        @(posedge clk_i);
        slow <= 1'b1;
        wr(8'h0A, 8'h10, 1'b0, 8'h00);
        wr(8'h0B, 8'h01, 1'b0, 8'h00);
        wr(8'h45, 8'h01, 1'b0, 8'h00);
        wr(8'h46, 8'h0D, 1'b0, 8'h00);
        wr(8'h46, 8'h04, 1'b0, 8'h01);
        wr(8'h3E, 8'h01, 1'b0, 8'h01);
        wr(8'h3D, 8'h01, 1'b1, 8'h00);
        drain();
        exp_set = '{8'h10, 8'h01, 8'h06, 8'h01, 8'h0D};
        check(stored_o, exp_set);
        check(applied_o, rlss_pkg::RST_SETTINGS);
        restart();
        check(applied_o, exp_set);
        check(append_strength_o, 1'b1);
        rx(8'h0F, 1'b1, 1'b1);
        check(serial_len_o, 8'h10);
        check(tx_format_b_o, 1'b1);
        rx(8'h10, 1'b0, 1'b0);
        check(serial_len_o, 8'h10);
        @(posedge clk_i);
        tx_req_len_i <= 8'h10;
        key_registered_i <= 1'b1;
        decrypt_busy_i <= 1'b1;
        #1;
        check(tx_len_ok_o, 1'b0);
        check(decrypt_run_o, 1'b1);
        check(rx_enable_o, 1'b0);
        @(posedge clk_i);
        tx_req_len_i <= 8'h0F;
        key_registered_i <= 1'b0;
        #1;
        check(tx_len_ok_o, 1'b1);
        check(decrypt_run_o, 1'b0);
        check(rx_enable_o, 1'b1);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_i);
            slow <= 1'($random(seed));
            wr(8'h46, modes[i], 1'b0, 8'h00);
            wr(8'h3D, 8'(i % 6 + 1), 1'b0, 8'h00);
            drain();
            restart();
            check(tx_power_dbm_o, dbm[i % 6]);
            check(tx_allowed_o, modes[i] != 8'h09);
            check(rx_allowed_o, !(modes[i] inside {8'h02, 8'h05, 8'h0C}));
            check(tx_format_b_o, 1'b0);
            if (!(modes[i] inside {8'h02, 8'h05, 8'h0C})) begin
                rx(8'h01, 1'b1, 1'b1);
                check(tx_format_b_o, modes[i] inside {8'h09, 8'h0D, 8'h0E});
            end
        end
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        check(applied_o, rlss_pkg::RST_SETTINGS);
        @(posedge clk_i);
        #1;
        exp_set = '{8'h10, 8'h01, 8'h03, 8'h01, 8'h0E};
        check(stored_o, exp_set);
        check(applied_o, exp_set);
        summarize();
    end
endmodule
